// *** logic/gpr_pkg.sv ***
// constants, register map and state types for the gpio port block
package gpr_pkg;

   localparam int ADDR_W   = 10;
   localparam int DATA_W   = 8;
   localparam int PE_W     = 2;
   localparam int PM_MAX_W = 4;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_PA    = 10'h000;
   localparam logic [ADDR_W-1:0] OFS_PB    = 10'h001;
   localparam logic [ADDR_W-1:0] OFS_DIRA  = 10'h002;
   localparam logic [ADDR_W-1:0] OFS_DIRB  = 10'h003;
   localparam logic [ADDR_W-1:0] OFS_PC    = 10'h004;
   localparam logic [ADDR_W-1:0] OFS_PD    = 10'h005;
   localparam logic [ADDR_W-1:0] OFS_DIRC  = 10'h006;
   localparam logic [ADDR_W-1:0] OFS_DIRD  = 10'h007;
   localparam logic [ADDR_W-1:0] OFS_PE    = 10'h008;
   localparam logic [ADDR_W-1:0] OFS_DIRE  = 10'h009;
   localparam logic [ADDR_W-1:0] OFS_PM    = 10'h250;
   localparam logic [ADDR_W-1:0] OFS_DDRM  = 10'h252;
   localparam logic [ADDR_W-1:0] OFS_ROUTE = 10'h254;

   // reset values
   localparam logic [DATA_W-1:0] REG_RST   = 8'h00;
   localparam logic              SCI_IDLE  = 1'b1;

   // route select codes, route register bits 3:2 timer, 1:0 serial
   localparam logic [1:0] TC2_PS5  = 2'h0;
   localparam logic [1:0] TC2_PE0  = 2'h1;
   localparam logic [1:0] TC2_PAD4 = 2'h2;
   localparam logic [1:0] SCI_PE   = 2'h0;
   localparam logic [1:0] SCI_PS   = 2'h1;
   localparam logic [1:0] SCI_PAD  = 2'h2;

   typedef struct packed {
      logic [1:0] tc2;
      logic [1:0] ser0;
   } gpr_route_t;

   typedef struct packed {
      logic [DATA_W-1:0]   lat_a;
      logic [DATA_W-1:0]   lat_b;
      logic [DATA_W-1:0]   lat_c;
      logic [DATA_W-1:0]   lat_d;
      logic [DATA_W-1:0]   dir_a;
      logic [DATA_W-1:0]   dir_b;
      logic [DATA_W-1:0]   dir_c;
      logic [DATA_W-1:0]   dir_d;
      logic [PE_W-1:0]     lat_e;
      logic [PE_W-1:0]     dir_e;
      logic [PM_MAX_W-1:0] lat_m;
      logic [PM_MAX_W-1:0] dir_m;
      gpr_route_t          route;
      logic [DATA_W-1:0]   rdata;
      logic [4*DATA_W-1:0] pin_abcd;
      logic [4*DATA_W-1:0] oe_b_abcd;
      logic [PE_W-1:0]     pin_e;
      logic [PE_W-1:0]     oe_b_e;
      logic [PM_MAX_W-1:0] pin_m;
      logic [PM_MAX_W-1:0] oe_b_m;
      logic                tc2_in;
      logic                ser0_rxd;
   } gpr_state_t;

endpackage : gpr_pkg

// *** logic/gpr_sync.sv ***
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module gpr_sync #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } gpr_sync_state_t;

   gpr_sync_state_t st_reg;
   gpr_sync_state_t st_next;

   // first stage feeds only the second stage
   always_comb
   begin
      st_next.s1 = d_i;
      st_next.s2 = st_reg.s1;
      if (!rst_b_i)
      begin
         st_next = '0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      st_reg <= st_next;
   end

   assign q_o = st_reg.s2;
endmodule : gpr_sync
`default_nettype wire

// *** logic/gpr_pin_bank.sv ***
// per-port read select and pin drive, peripheral claim first
`timescale 1ns/10ps
`default_nettype none
module gpr_pin_bank #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] lat_i,
   input  wire logic [W-1:0] dir_i,
   input  wire logic [W-1:0] pin_s_i,
   input  wire logic [W-1:0] claim_i,
   input  wire logic [W-1:0] alt_out_i,
   input  wire logic [W-1:0] alt_oe_i,
   output logic      [W-1:0] rd_val_o,
   output logic      [W-1:0] drv_o,
   output logic      [W-1:0] oe_b_o
);
   // read: latch where output, synced pin where input; no other setting matters
   assign rd_val_o = (lat_i & dir_i) | (pin_s_i & ~dir_i);

   // a claimed pin follows its peripheral, else the latch drives outputs
   assign drv_o  = (claim_i & alt_out_i) | (~claim_i & lat_i);
   assign oe_b_o = ~((claim_i & alt_oe_i) | (~claim_i & dir_i));
endmodule : gpr_pin_bank
`default_nettype wire

// *** logic/gpr_port_top.sv ***
// gpio ports a-e and m: registers, pin drive, read select and routing
`timescale 1ns/10ps
`default_nettype none
module gpr_port_top
   import gpr_pkg::*;
#(
   parameter int PM_BITS = 4
) (
   input  wire logic                clk_i,
   input  wire logic                rst_b_i,
   input  wire logic [ADDR_W-1:0]   addr_i,
   input  wire logic [DATA_W-1:0]   wdata_i,
   input  wire logic                wr_i,
   input  wire logic                rd_i,
   output logic      [DATA_W-1:0]   rdata_o,
   input  wire logic [4*DATA_W-1:0] pabcd_pin_i,
   output logic      [4*DATA_W-1:0] pabcd_pin_o,
   output logic      [4*DATA_W-1:0] pabcd_oe_b_o,
   input  wire logic [PE_W-1:0]     pe_pin_i,
   output logic      [PE_W-1:0]     pe_pin_o,
   output logic      [PE_W-1:0]     pe_oe_b_o,
   input  wire logic [PM_MAX_W-1:0] pm_pin_i,
   output logic      [PM_MAX_W-1:0] pm_pin_o,
   output logic      [PM_MAX_W-1:0] pm_oe_b_o,
   input  wire logic [PM_MAX_W-1:0] pm_claim_i,
   input  wire logic [PM_MAX_W-1:0] pm_alt_out_i,
   input  wire logic [PM_MAX_W-1:0] pm_alt_oe_i,
   input  wire logic                ps5_pin_i,
   input  wire logic                ps4_pin_i,
   input  wire logic                pad4_pin_i,
   input  wire logic                tc2_out_i,
   input  wire logic                tc2_oe_i,
   input  wire logic                ser0_txd_i,
   output logic                     tc2_in_o,
   output logic                     ser0_rxd_o,
   output logic      [1:0]          tc2_route_o,
   output logic      [1:0]          ser0_route_o
);
   localparam int SYNC_W = 4*DATA_W + PE_W + PM_MAX_W + 3;
   // implemented port m bits; upper latch and direction bits stay zero
   localparam logic [PM_MAX_W-1:0] PM_MASK = PM_MAX_W'((1 << PM_BITS) - 1);

   gpr_state_t st_reg;
   gpr_state_t st_next;

   logic [SYNC_W-1:0]   sync_q;
   logic [4*DATA_W-1:0] abcd_s;
   logic [PE_W-1:0]     pe_s;
   logic [PM_MAX_W-1:0] pm_s;
   logic                ps5_s;
   logic                ps4_s;
   logic                pad4_s;
   logic [4*DATA_W-1:0] rd_abcd;
   logic [4*DATA_W-1:0] drv_abcd;
   logic [4*DATA_W-1:0] oe_b_abcd;
   logic [PE_W-1:0]     rd_e;
   logic [PE_W-1:0]     drv_e;
   logic [PE_W-1:0]     oe_b_e;
   logic [PE_W-1:0]     claim_e;
   logic [PE_W-1:0]     alt_out_e;
   logic [PE_W-1:0]     alt_oe_e;
   logic [PM_MAX_W-1:0] rd_m;
   logic [PM_MAX_W-1:0] drv_m;
   logic [PM_MAX_W-1:0] oe_b_m;
   logic                tc2_on_pe;
   logic                sci_on_pe;

   // every pin level crosses two flops before the read select sees it
   gpr_sync #(
      .W (SYNC_W)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .d_i     ({pabcd_pin_i, pe_pin_i, pm_pin_i, ps5_pin_i, ps4_pin_i, pad4_pin_i}),
      .q_o     (sync_q)
   );

   assign {abcd_s, pe_s, pm_s, ps5_s, ps4_s, pad4_s} = sync_q;

   // ports a to d have no alternate function in this block
   gpr_pin_bank #(
      .W (4*DATA_W)
   ) u_bank_abcd (
      .lat_i     ({st_reg.lat_a, st_reg.lat_b, st_reg.lat_c, st_reg.lat_d}),
      .dir_i     ({st_reg.dir_a, st_reg.dir_b, st_reg.dir_c, st_reg.dir_d}),
      .pin_s_i   (abcd_s),
      .claim_i   ('0),
      .alt_out_i ('0),
      .alt_oe_i  ('0),
      .rd_val_o  (rd_abcd),
      .drv_o     (drv_abcd),
      .oe_b_o    (oe_b_abcd)
   );

   // port e claims: timer wins pe0 over serial receive when both pick it
   assign tc2_on_pe = (st_reg.route.tc2 == TC2_PE0);
   assign sci_on_pe = (st_reg.route.ser0 == SCI_PE);
   assign claim_e   = {sci_on_pe, tc2_on_pe | sci_on_pe};
   assign alt_out_e = {ser0_txd_i, tc2_on_pe & tc2_out_i};
   assign alt_oe_e  = {1'b1, tc2_on_pe & tc2_oe_i};

   gpr_pin_bank #(
      .W (PE_W)
   ) u_bank_e (
      .lat_i     (st_reg.lat_e),
      .dir_i     (st_reg.dir_e),
      .pin_s_i   (pe_s),
      .claim_i   (claim_e),
      .alt_out_i (alt_out_e),
      .alt_oe_i  (alt_oe_e),
      .rd_val_o  (rd_e),
      .drv_o     (drv_e),
      .oe_b_o    (oe_b_e)
   );

   // port m: peripherals may take any implemented pin
   gpr_pin_bank #(
      .W (PM_MAX_W)
   ) u_bank_m (
      .lat_i     (st_reg.lat_m),
      .dir_i     (st_reg.dir_m),
      .pin_s_i   (pm_s & PM_MASK),
      .claim_i   (pm_claim_i & PM_MASK),
      .alt_out_i (pm_alt_out_i),
      .alt_oe_i  (pm_alt_oe_i),
      .rd_val_o  (rd_m),
      .drv_o     (drv_m),
      .oe_b_o    (oe_b_m)
   );

   // next state: register writes, read data, pin outputs, routed inputs
   always_comb
   begin
      st_next = st_reg;
      // writes; masks keep unimplemented bits at zero whatever is written
      if (wr_i)
      begin
         case (addr_i)
            OFS_PA:    st_next.lat_a = wdata_i;
            OFS_PB:    st_next.lat_b = wdata_i;
            OFS_DIRA:  st_next.dir_a = wdata_i;
            OFS_DIRB:  st_next.dir_b = wdata_i;
            OFS_PC:    st_next.lat_c = wdata_i;
            OFS_PD:    st_next.lat_d = wdata_i;
            OFS_DIRC:  st_next.dir_c = wdata_i;
            OFS_DIRD:  st_next.dir_d = wdata_i;
            OFS_PE:    st_next.lat_e = wdata_i[PE_W-1:0];
            OFS_DIRE:  st_next.dir_e = wdata_i[PE_W-1:0];
            OFS_PM:    st_next.lat_m = wdata_i[PM_MAX_W-1:0] & PM_MASK;
            OFS_DDRM:  st_next.dir_m = wdata_i[PM_MAX_W-1:0] & PM_MASK;
            OFS_ROUTE: st_next.route = wdata_i[3:0];
            default:   st_next.rdata = st_reg.rdata; // unmapped write ignored
         endcase
      end
      // read data stands for one cycle only; unmapped reads return zero
      st_next.rdata = REG_RST;
      if (rd_i)
      begin
         case (addr_i)
            OFS_PA:    st_next.rdata = rd_abcd[4*DATA_W-1:3*DATA_W];
            OFS_PB:    st_next.rdata = rd_abcd[3*DATA_W-1:2*DATA_W];
            OFS_DIRA:  st_next.rdata = st_reg.dir_a;
            OFS_DIRB:  st_next.rdata = st_reg.dir_b;
            OFS_PC:    st_next.rdata = rd_abcd[2*DATA_W-1:DATA_W];
            OFS_PD:    st_next.rdata = rd_abcd[DATA_W-1:0];
            OFS_DIRC:  st_next.rdata = st_reg.dir_c;
            OFS_DIRD:  st_next.rdata = st_reg.dir_d;
            OFS_PE:    st_next.rdata = DATA_W'(rd_e);
            OFS_DIRE:  st_next.rdata = DATA_W'(st_reg.dir_e);
            OFS_PM:    st_next.rdata = DATA_W'(rd_m & PM_MASK);
            OFS_DDRM:  st_next.rdata = DATA_W'(st_reg.dir_m);
            OFS_ROUTE: st_next.rdata = DATA_W'(st_reg.route);
            default:   st_next.rdata = REG_RST;
         endcase
      end
      // pins are registered so every output leaves a flop
      st_next.pin_abcd  = drv_abcd;
      st_next.oe_b_abcd = oe_b_abcd;
      st_next.pin_e     = drv_e;
      st_next.oe_b_e    = oe_b_e;
      st_next.pin_m     = drv_m;
      st_next.oe_b_m    = oe_b_m;
      // timer capture input source; reserved code reads low
      case (st_reg.route.tc2)
         TC2_PS5:  st_next.tc2_in = ps5_s;
         TC2_PE0:  st_next.tc2_in = pe_s[0];
         TC2_PAD4: st_next.tc2_in = pad4_s;
         default:  st_next.tc2_in = 1'b0;
      endcase
      // serial receive source; reserved code holds the line idle
      case (st_reg.route.ser0)
         SCI_PE:  st_next.ser0_rxd = pe_s[0];
         SCI_PS:  st_next.ser0_rxd = ps4_s;
         SCI_PAD: st_next.ser0_rxd = pad4_s;
         default: st_next.ser0_rxd = SCI_IDLE;
      endcase
      // reset: all pins inputs, latches and directions clear
      if (!rst_b_i)
      begin
         st_next           = '0;
         st_next.oe_b_abcd = '1;
         st_next.oe_b_e    = '1;
         st_next.oe_b_m    = '1;
         st_next.ser0_rxd  = SCI_IDLE;
      end
   end

   always_ff @(posedge clk_i)
   begin
      st_reg <= st_next;
   end

   // outputs straight from the state flops
   assign rdata_o       = st_reg.rdata;
   assign pabcd_pin_o   = st_reg.pin_abcd;
   assign pabcd_oe_b_o  = st_reg.oe_b_abcd;
   assign pe_pin_o      = st_reg.pin_e;
   assign pe_oe_b_o     = st_reg.oe_b_e;
   assign pm_pin_o      = st_reg.pin_m;
   assign pm_oe_b_o     = st_reg.oe_b_m;
   assign tc2_in_o      = st_reg.tc2_in;
   assign ser0_rxd_o    = st_reg.ser0_rxd;
   assign tc2_route_o   = st_reg.route.tc2;
   assign ser0_route_o  = st_reg.route.ser0;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // read data only in the cycle after a read strobe
   a_rdata_idle_zero : assert property (!$past(rd_i) |-> rdata_o == REG_RST)
      else $error("read data not zero outside read answer");

   a_pe_upper_zero : assert property (
      $past(rd_i && (addr_i == OFS_PE || addr_i == OFS_DIRE))
      |-> rdata_o[DATA_W-1:PE_W] == '0)
      else $error("port e upper bits not zero");

   a_pm_upper_zero : assert property (
      $past(rd_i && addr_i == OFS_PM) |-> (rdata_o & ~DATA_W'(PM_MASK)) == '0)
      else $error("port m unimplemented bits not zero");

   a_pa_read_mux : assert property (
      $past(rd_i && addr_i == OFS_PA)
      |-> rdata_o == $past((st_reg.lat_a & st_reg.dir_a)
                          | (abcd_s[4*DATA_W-1:3*DATA_W] & ~st_reg.dir_a)))
      else $error("port a read select wrong");

   a_pd_write_read : assert property (
      (wr_i && addr_i == OFS_DIRD) ##1 (rd_i && addr_i == OFS_DIRD)
      |=> rdata_o == $past(wdata_i, 2))
      else $error("direction d write not read back");

   a_pa_drive : assert property (
      pabcd_pin_o[4*DATA_W-1:3*DATA_W] == $past(st_reg.lat_a)
      && pabcd_oe_b_o[4*DATA_W-1:3*DATA_W] == ~$past(st_reg.dir_a))
      else $error("port a pin drive does not follow latch");

   a_reset_clear : assert property (
      $rose(rst_b_i) |-> st_reg.dir_a == '0 && st_reg.lat_e == '0
      && pabcd_oe_b_o == '1 && pe_oe_b_o == '1)
      else $error("port state not cleared by reset");

   a_tc2_pe0_route : assert property (
      $past(st_reg.route.tc2 == TC2_PE0) |-> tc2_in_o == $past(pe_s[0]))
      else $error("timer channel 2 not taken from pe0");

   // pins are still inputs at the first edge after reset, so that edge is left out
   a_ser0_tx_pe1 : assert property (
      $past(rst_b_i && st_reg.route.ser0 == SCI_PE)
      |-> pe_pin_o[1] == $past(ser0_txd_i) && !pe_oe_b_o[1])
      else $error("serial transmit not on pe1");

   a_pm_claim_wins : assert property (
      $past(pm_claim_i[0])
      |-> pm_pin_o[0] == $past(pm_alt_out_i[0])
      && pm_oe_b_o[0] == !$past(pm_alt_oe_i[0]))
      else $error("port m claim does not override latch");

   // without a claim the latch and direction own the pin
   a_pm_gpio_drive : assert property (
      $past(!pm_claim_i[0])
      |-> pm_pin_o[0] == $past(st_reg.lat_m[0])
      && pm_oe_b_o[0] == !$past(st_reg.dir_m[0]))
      else $error("unclaimed port m pin does not follow latch");

   // register writes land one edge later, cut to the implemented bits
   a_pe_write_mask : assert property (
      $past(wr_i && addr_i == OFS_PE)
      |-> st_reg.lat_e == $past(wdata_i[PE_W-1:0]))
      else $error("port e latch not loaded from low write bits");

   a_pm_latch_write : assert property (
      $past(wr_i && addr_i == OFS_PM)
      |-> st_reg.lat_m == ($past(wdata_i[PM_MAX_W-1:0]) & PM_MASK))
      else $error("port m latch not loaded under its mask");

   // read select of the narrow ports; the pin side is already synchronised,
   // so the answer reflects the pin two edges before the read edge
   a_pe_read_mux : assert property (
      $past(rd_i && addr_i == OFS_PE)
      |-> rdata_o == DATA_W'($past((st_reg.lat_e & st_reg.dir_e) | (pe_s & ~st_reg.dir_e))))
      else $error("port e read select wrong");

   a_pm_read_mux : assert property (
      $past(rd_i && addr_i == OFS_PM)
      |-> rdata_o[PM_MAX_W-1:0] == $past((st_reg.lat_m & st_reg.dir_m)
                                       | (pm_s & PM_MASK & ~st_reg.dir_m)))
      else $error("port m read select wrong");

   // route codes come straight from the written byte
   a_route_write : assert property (
      $past(wr_i && addr_i == OFS_ROUTE)
      |-> {tc2_route_o, ser0_route_o} == $past(wdata_i[3:0]))
      else $error("route codes not loaded from write");

   // routed inputs follow the code one edge after the synchroniser
   a_ser0_rx_route : assert property (
      $past(st_reg.route.ser0 == SCI_PS) |-> ser0_rxd_o == $past(ps4_s))
      else $error("serial receive not taken from ps4");

   // a reserved timer code must not pass a stray pin edge to the capture
   a_tc2_reserved_low : assert property (
      $past(&st_reg.route.tc2) |-> !tc2_in_o)
      else $error("timer input not low on reserved code");

   // the gap between port e and port m decodes nothing
   a_unmapped_read : assert property (
      $past(rd_i && addr_i > OFS_DIRE && addr_i < OFS_PM) |-> rdata_o == REG_RST)
      else $error("unmapped read not zero");
endmodule : gpr_port_top
`default_nettype wire

// *** verification/gpr_pin_model.sv ***
// package pins seen from outside: device drive, external drive or a floating line
`timescale 1ns/10ps
`default_nettype none
module gpr_pin_model #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic [W-1:0] drv_i,
   input  wire logic [W-1:0] oe_b_i,
   input  wire logic [W-1:0] ext_i,
   input  wire logic [W-1:0] ext_en_i,
   output logic      [W-1:0] pin_o
);
   logic [W-1:0] flo_reg = '0;

   // an undriven line toggles every cycle so a stale level never reads as valid
   always_ff @(posedge clk_i)
   begin
      flo_reg <= ~flo_reg;
   end

   // both sides driving gives an unknown level, a fight is never resolved kindly
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         if (!oe_b_i[i] && ext_en_i[i])
            pin_o[i] = 1'bx;
         else if (!oe_b_i[i])
            pin_o[i] = drv_i[i];
         else if (ext_en_i[i])
            pin_o[i] = ext_i[i];
         else
            pin_o[i] = flo_reg[i];
      end
   end
endmodule : gpr_pin_model
`default_nettype wire

// *** verification/gpr_port_top_bench.sv ***
// self-checking bench for the gpio port block
`timescale 1ns/10ps
`default_nettype none
module gpr_port_top_bench
   import gpr_pkg::*;
;
   logic              clk_i, rst_b_i, wr_i, rd_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wdata_i, rdata_o;
   logic [31:0]       ab_pin, ab_out, ab_oe_b, ab_ext, ab_en;
   logic [1:0]        pe_pin, pe_out, pe_oe_b, pe_ext, pe_en, tc2_route, ser0_route;
   logic [3:0]        pm_pin, pm_out, pm_oe_b, pm_ext, pm_en, claim, alt_out, alt_oe, src;
   logic              tc2_out, tc2_oe, txd, tc2_in, rxd;
   int                n_fail, n_tests, cyc;
   logic [ADDR_W-1:0] dat_ofs [4] = '{OFS_PA, OFS_PB, OFS_PC, OFS_PD};
   logic [ADDR_W-1:0] dir_ofs [4] = '{OFS_DIRA, OFS_DIRB, OFS_DIRC, OFS_DIRD};

   gpr_port_top #(.PM_BITS(4)) gpr_port_top_i (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pabcd_pin_i(ab_pin),
      .pabcd_pin_o(ab_out), .pabcd_oe_b_o(ab_oe_b), .pe_pin_i(pe_pin), .pe_pin_o(pe_out),
      .pe_oe_b_o(pe_oe_b), .pm_pin_i(pm_pin), .pm_pin_o(pm_out), .pm_oe_b_o(pm_oe_b),
      .pm_claim_i(claim), .pm_alt_out_i(alt_out), .pm_alt_oe_i(alt_oe),
      .ps5_pin_i(src[3]), .ps4_pin_i(src[0]), .pad4_pin_i(src[1]), .tc2_out_i(tc2_out),
      .tc2_oe_i(tc2_oe), .ser0_txd_i(txd), .tc2_in_o(tc2_in), .ser0_rxd_o(rxd),
      .tc2_route_o(tc2_route), .ser0_route_o(ser0_route));

   gpr_pin_model #(.W(32)) pins_abcd (.clk_i(clk_i), .drv_i(ab_out), .oe_b_i(ab_oe_b),
      .ext_i(ab_ext), .ext_en_i(ab_en), .pin_o(ab_pin));
   gpr_pin_model #(.W(2)) pins_e (.clk_i(clk_i), .drv_i(pe_out), .oe_b_i(pe_oe_b),
      .ext_i(pe_ext), .ext_en_i(pe_en), .pin_o(pe_pin));
   gpr_pin_model #(.W(4)) pins_m (.clk_i(clk_i), .drv_i(pm_out), .oe_b_i(pm_oe_b),
      .ext_i(pm_ext), .ext_en_i(pm_en), .pin_o(pm_pin));

   task automatic tally_and_finish;
      if (n_fail == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask : chk

   // one-cycle write strobe, released on the following edge
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe, so look there
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1;
      chk(nm, {24'h0, e}, {24'h0, rdata_o});
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : settle

   // timer source per code; sources packed {ps5, pe0, pad4, ps4}
   function automatic logic exp_tc(input int c, input logic [3:0] s);
      return (c == 0) ? s[3] : (c == 1) ? s[2] : (c == 2) ? s[1] : 1'b0;
   endfunction : exp_tc

   function automatic logic exp_rx(input int c, input logic [3:0] s);
      return (c == 0) ? s[2] : (c == 1) ? s[0] : (c == 2) ? s[1] : 1'b1;
   endfunction : exp_rx

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // hang guard, over ten times the expected run length
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial
   begin
      logic [7:0] pat;
      logic [3:0] one;
      {rst_b_i, wr_i, rd_i, addr_i, wdata_i} = '0;
      {ab_ext, ab_en, pe_ext, pe_en, pm_ext, pm_en} = '0;
      {claim, alt_out, alt_oe, src, tc2_out, tc2_oe, txd} = '0;
      {n_fail, n_tests, cyc} = '0;
      // reset is sampled low at two edges: this one and the release edge
      @(posedge clk_i);
      #1;
      chk("abcd oe_b in reset", 32'hffffffff, ab_oe_b);
      chk("m oe_b in reset", 32'hf, {28'h0, pm_oe_b});
      @(posedge clk_i);
      rst_b_i <= 1'b1;
      for (int p = 0; p < 4; p++)
      begin
         pat = 8'ha5 + 8'(p);
         rd(dir_ofs[p], 8'h00, "direction after reset");
         wr(dir_ofs[p], 8'hff);
         rd(dat_ofs[p], 8'h00, "latch after reset");
         wr(dat_ofs[p], pat);
         rd(dat_ofs[p], pat, "latch readback");
         settle(1);
         chk("pin drive", {24'h0, pat}, {24'h0, ab_out[31-8*p -: 8]});
         chk("pin enable", 32'h0, {24'h0, ab_oe_b[31-8*p -: 8]});
         wr(dir_ofs[p], 8'h0f);
         @(posedge clk_i);
         ab_ext[31-8*p -: 8] <= 8'h3c;
         ab_en[31-8*p -: 8]  <= 8'hf0;
         settle(4);
         chk("mixed enable", 32'hf0, {24'h0, ab_oe_b[31-8*p -: 8]});
         rd(dat_ofs[p], (pat & 8'h0f) | 8'h30, "mixed read");
      end
      // write then read with no idle cycle between the strobes
      @(posedge clk_i);
      addr_i  <= OFS_DIRD;
      wdata_i <= 8'h07;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
      rd_i    <= 1'b1;
      @(posedge clk_i);
      rd_i    <= 1'b0;
      #1;
      chk("back-to-back readback", 32'h07, {24'h0, rdata_o});
      rd(OFS_DIRE, 8'h00, "port e direction after reset");
      wr(OFS_PE, 8'h03);
      wr(OFS_DIRE, 8'h03);
      rd(OFS_PE, 8'h03, "port e latch width");
      rd(OFS_DIRE, 8'h03, "port e direction width");
      wr(OFS_DIRE, 8'h00);
      wr(10'h00a, 8'hff);
      rd(10'h00a, 8'h00, "unmapped read");
      @(posedge clk_i);
      #1;
      chk("read data after its cycle", 32'h0, {24'h0, rdata_o});
      wr(OFS_DDRM, 8'h0f);
      rd(OFS_PM, 8'h00, "port m after reset");
      wr(OFS_PM, 8'h0f);
      rd(OFS_PM, 8'h0f, "port m width");
      chk("port m drive", 32'h0f, {24'h0, pm_oe_b, pm_out});
      @(posedge clk_i);
      claim   <= 4'h1;
      alt_oe  <= 4'h1;
      settle(2);
      chk("claimed pin", 32'h0e, {24'h0, pm_oe_b, pm_out});
      @(posedge clk_i);
      alt_oe  <= 4'h0;
      settle(2);
      chk("claimed pin released", 32'h1, {28'h0, pm_oe_b});
      rd(OFS_PM, 8'h0f, "claimed read");
      @(posedge clk_i);
      claim   <= 4'h0;
      wr(OFS_DDRM, 8'h00);
      // outside drive starts on the edge at which the block lets go of the pins
      @(posedge clk_i);
      pm_ext  <= 4'h5;
      pm_en   <= 4'hf;
      settle(4);
      rd(OFS_PM, 8'h05, "port m input read");
      @(posedge clk_i);
      pe_en <= 2'b01;
      for (int c = 0; c < 4; c++)
      begin
         wr(OFS_ROUTE, {4'h0, 2'(c), 2'(c)});
         rd(OFS_ROUTE, {4'h0, 2'(c), 2'(c)}, "route readback");
         chk("route codes", {28'h0, 2'(c), 2'(c)}, {28'h0, tc2_route, ser0_route});
         for (int k = 0; k < 4; k++)
         begin
            one = 4'b0001 << k;
            @(posedge clk_i);
            src    <= one;
            pe_ext <= {1'b0, one[2]};
            txd    <= one[0];
            settle(4);
            chk("timer input", {31'h0, exp_tc(c, one)}, {31'h0, tc2_in});
            chk("serial receive", {31'h0, exp_rx(c, one)}, {31'h0, rxd});
            if (c == 0)
               chk("serial transmit pin", {30'h0, 1'b0, one[0]}, {30'h0, pe_oe_b[1], pe_out[1]});
         end
      end
      wr(OFS_ROUTE, 8'h07);
      @(posedge clk_i);
      pe_en   <= 2'b00;
      tc2_oe  <= 1'b1;
      tc2_out <= 1'b1;
      settle(3);
      chk("timer drives pe0", 32'h1, {30'h0, pe_oe_b[0], pe_out[0]});
      tally_and_finish();
   end
endmodule : gpr_port_top_bench
`default_nettype wire
